// >>> include/pcs_pkg.sv
// Package for the programmable select decoder: register indexes, field
// positions, reset values and APB constants. Assumes a 32-bit APB bus.
package pcs_pkg;
    localparam int unsigned NUM_SEL      = 4;
    localparam int unsigned CMP_W        = 10;
    localparam int unsigned PADDR_W      = 12;

    // Register indexes as printed; the byte address is four times the index.
    localparam logic [9:0] IDX_BASE0     = 10'h04a;
    localparam logic [9:0] IDX_CTRL0     = 10'h04b;
    localparam logic [9:0] IDX_BASE1     = 10'h04c;
    localparam logic [9:0] IDX_CTRL1     = 10'h04d;
    localparam logic [9:0] IDX_CYC_TYPE  = 10'h0b3;
    localparam logic [9:0] IDX_BASE2     = 10'h0ba;
    localparam logic [9:0] IDX_CTRL2     = 10'h0bb;
    localparam logic [9:0] IDX_BASE3     = 10'h0bc;
    localparam logic [9:0] IDX_CTRL3     = 10'h0bd;
    localparam logic [9:0] IDX_GRAN      = 10'h0bf;
    localparam logic [9:0] IDX_GLOBAL    = 10'h0fe;

    // Reset values.
    localparam logic [7:0] RST_BASE      = 8'h00;
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_CYC_TYPE  = 8'h00;
    localparam logic [7:0] RST_GRAN      = 8'h0f;
    localparam logic [7:0] RST_GLOBAL    = 8'h00;

    // Control register fields.
    localparam int unsigned CTRL_TOP_BIT = 7;
    localparam int unsigned CTRL_WR_EN   = 6;
    localparam int unsigned CTRL_RD_EN   = 5;
    localparam int unsigned CTRL_EARLY   = 4;
    localparam int unsigned CTRL_MASK_LO = 0;
    localparam int unsigned CTRL_MASK_W  = 4;

    // Shared register field offsets; bit n of a field serves select n.
    localparam int unsigned GRAN_BASE_LO = 4;
    localparam int unsigned GRAN_MASK_LO = 0;
    localparam int unsigned TYPE_MEM_LO  = 0;
    localparam int unsigned TYPE_WID_LO  = 4;
    localparam int unsigned GLB_DIR_LO   = 0;
    localparam int unsigned GLB_DIS_LO   = 4;

    // Address windows compared in each mode.
    localparam int unsigned IO_CMP_LO    = 0;
    localparam int unsigned MEM_CMP_LO   = 14;

    localparam logic [1:0] APB_ALIGN     = 2'h0;
    localparam logic [1:0] APB_HI_ZERO   = 2'h0;
endpackage

// >>> hw/pcs_decoder.sv
// Four programmable chip-select decoders with their register bank on APB.
// Assumes one clock, bus-cycle inputs synchronous to pclk, and an APB
// master that keeps to the usual setup and access phases.

// Function
// - Four selects, each memory or I/O decode
// - I/O mode compares ten bits, byte granularity
// - Memory mode decodes 16KB blocks over 16MB
// - Base register compares A8-A1 or A22-A15
// - Control bit 7 compares A9 or A23
// - Control bits enable write and read decode
// - Control bit 4 picks command or early timing
// - Control mask bits exclude base bits from compare
// - Granularity register adds lowest base and mask
// - Granularity register resets to 0Fh
// - Cycle-type high bits give ROM width
// - Global bits disable each select's decode
// - One write disables decode, enables kept
// - Global disables reset to enabled state
// - Global low bits let read hits drive direction low
// - Select read hits and the direction input steer peripheral buffer direction
module pcs_decoder
    import pcs_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [PADDR_W-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 cyc_valid,
    input  wire logic                 cyc_is_mem,
    input  wire logic                 cyc_is_write,
    input  wire logic                 cyc_cmd,
    input  wire logic [23:0]          cyc_addr,
    input  wire logic                 peripheral_buffer_direction_in,
    output logic      [NUM_SEL-1:0]   programmable_select_n,
    output logic                      peripheral_buffer_direction,
    output logic                      rom_select_cycle,
    output logic                      rom_select_wide
);

    logic [7:0]          base_ff [NUM_SEL];
    logic [7:0]          ctrl_ff [NUM_SEL];
    logic [7:0]          cyc_type_ff;
    logic [7:0]          gran_ff;
    logic [7:0]          global_ff;
    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic [NUM_SEL-1:0]  sel_n_ff;
    logic                dir_ff;
    logic                rom_cyc_ff;
    logic                rom_wide_ff;
    logic [9:0]          reg_idx;
    logic                addr_ok;
    logic                wr_en;
    logic [NUM_SEL-1:0]  match;
    logic [NUM_SEL-1:0]  hit;
    logic [NUM_SEL-1:0]  rd_hit;
    logic [CMP_W-1:0]    cyc_cmp;

    // Says whether an index names one of the registers of the bank.
    function automatic logic reg_mapped(input logic [9:0] idx);
        unique case (idx)
            IDX_BASE0, IDX_CTRL0, IDX_BASE1, IDX_CTRL1, IDX_CYC_TYPE,
            IDX_BASE2, IDX_CTRL2, IDX_BASE3, IDX_CTRL3, IDX_GRAN,
            IDX_GLOBAL: reg_mapped = 1'b1;
            default:    reg_mapped = 1'b0;
        endcase
    endfunction

    // Base and control register indexes of select n.
    function automatic logic [9:0] base_idx(input int unsigned n);
        unique case (n)
            0:       base_idx = IDX_BASE0;
            1:       base_idx = IDX_BASE1;
            2:       base_idx = IDX_BASE2;
            default: base_idx = IDX_BASE3;
        endcase
    endfunction

    function automatic logic [9:0] ctrl_idx(input int unsigned n);
        unique case (n)
            0:       ctrl_idx = IDX_CTRL0;
            1:       ctrl_idx = IDX_CTRL1;
            2:       ctrl_idx = IDX_CTRL2;
            default: ctrl_idx = IDX_CTRL3;
        endcase
    endfunction

    // Ten-bit compare value of select n: top bit, base byte, lowest bit.
    function automatic logic [CMP_W-1:0] cmp_base(input logic [7:0] ctrl,
                                                  input logic [7:0] base,
                                                  input logic       low);
        cmp_base = {ctrl[CTRL_TOP_BIT], base, low};
    endfunction

    // Ten-bit mask of select n; only the five lowest bits can be masked.
    function automatic logic [CMP_W-1:0] cmp_mask(input logic [7:0] ctrl,
                                                  input logic       low);
        cmp_mask = {5'h00, ctrl[CTRL_MASK_LO +: CTRL_MASK_W], low};
    endfunction

    assign reg_idx = paddr[PADDR_W-1:2];
    assign addr_ok = (paddr[1:0] == APB_ALIGN) && reg_mapped(reg_idx);
    assign wr_en   = psel && penable && pready_ff && pwrite && addr_ok;

    // Memory cycles compare A23-A14, I/O cycles A9-A0.
    assign cyc_cmp = cyc_is_mem ? cyc_addr[MEM_CMP_LO +: CMP_W]
                                : cyc_addr[IO_CMP_LO +: CMP_W];

    always_comb begin
        for (int i = 0; i < NUM_SEL; i++) begin
            match[i] = ((cyc_cmp ^ cmp_base(ctrl_ff[i], base_ff[i],
                                             gran_ff[GRAN_BASE_LO + i]))
                        & ~cmp_mask(ctrl_ff[i], gran_ff[GRAN_MASK_LO + i]))
                       == '0;
            hit[i] = match[i]
                  && (cyc_is_mem == cyc_type_ff[TYPE_MEM_LO + i])
                  && (cyc_is_write ? ctrl_ff[i][CTRL_WR_EN]
                                   : ctrl_ff[i][CTRL_RD_EN])
                  && !global_ff[GLB_DIS_LO + i]
                  && (ctrl_ff[i][CTRL_EARLY] ? cyc_valid
                                             : cyc_valid && cyc_cmd);
            rd_hit[i] = hit[i] && !cyc_is_write && global_ff[GLB_DIR_LO + i];
        end
    end

    // Per-select base and control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                base_ff[i] <= RST_BASE;
                ctrl_ff[i] <= RST_CTRL;
            end
        end else if (wr_en) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                if (reg_idx == base_idx(i)) begin
                    base_ff[i] <= pwdata[7:0];
                end
                if (reg_idx == ctrl_idx(i)) begin
                    ctrl_ff[i] <= pwdata[7:0];
                end
            end
        end
    end

    // Shared registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_type_ff <= RST_CYC_TYPE;
            gran_ff     <= RST_GRAN;
            global_ff   <= RST_GLOBAL;
        end else if (wr_en) begin
            if (reg_idx == IDX_CYC_TYPE) begin
                cyc_type_ff <= pwdata[7:0];
            end
            if (reg_idx == IDX_GRAN) begin
                gran_ff <= pwdata[7:0];
            end
            if (reg_idx == IDX_GLOBAL) begin
                global_ff <= pwdata[7:0];
            end
        end
    end

    // APB answer: one wait-free access phase, data captured at setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite) begin
                prdata_ff <= '0;
                for (int i = 0; i < NUM_SEL; i++) begin
                    if (reg_idx == base_idx(i)) begin
                        prdata_ff[7:0] <= base_ff[i];
                    end
                    if (reg_idx == ctrl_idx(i)) begin
                        prdata_ff[7:0] <= ctrl_ff[i];
                    end
                end
                if (reg_idx == IDX_CYC_TYPE) begin
                    prdata_ff[7:0] <= cyc_type_ff;
                end
                if (reg_idx == IDX_GRAN) begin
                    prdata_ff[7:0] <= gran_ff;
                end
                if (reg_idx == IDX_GLOBAL) begin
                    prdata_ff[7:0] <= global_ff;
                end
                if (paddr[1:0] != APB_ALIGN) begin
                    prdata_ff <= '0;
                end
            end
        end
    end

    // Select outputs, buffer direction and ROM cycle flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_n_ff    <= '1;
            dir_ff      <= 1'b1;
            rom_cyc_ff  <= 1'b0;
            rom_wide_ff <= 1'b0;
        end else begin
            sel_n_ff    <= ~hit;
            dir_ff      <= peripheral_buffer_direction_in && !(|rd_hit);
            rom_cyc_ff  <= cyc_is_mem && (|hit);
            rom_wide_ff <= cyc_is_mem
                        && (|(hit & cyc_type_ff[TYPE_WID_LO +: NUM_SEL]));
        end
    end

    assign prdata                      = prdata_ff;
    assign pready                      = pready_ff;
    assign pslverr                     = pslverr_ff;
    assign programmable_select_n       = sel_n_ff;
    assign peripheral_buffer_direction = dir_ff;
    assign rom_select_cycle            = rom_cyc_ff;
    assign rom_select_wide             = rom_wide_ff;

    default clocking dflt_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    global_disable_a: assert property (
        global_ff[GLB_DIS_LO] |=> programmable_select_n[0])
        else $error("Select 0 asserted while globally disabled.");

    read_enable_a: assert property (
        cyc_valid && !cyc_is_write && !ctrl_ff[0][CTRL_RD_EN]
        |=> programmable_select_n[0])
        else $error("Select 0 asserted on a read with read decode off.");

    write_enable_a: assert property (
        cyc_valid && cyc_is_write && !ctrl_ff[0][CTRL_WR_EN]
        |=> programmable_select_n[0])
        else $error("Select 0 asserted on a write with write decode off.");

    cycle_type_a: assert property (
        cyc_is_mem != cyc_type_ff[TYPE_MEM_LO]
        |=> programmable_select_n[0])
        else $error("Select 0 asserted on the wrong cycle type.");

    cmd_timing_a: assert property (
        !ctrl_ff[1][CTRL_EARLY] && !cyc_cmd |=> programmable_select_n[1])
        else $error("Select 1 asserted before the command.");

    addr_mismatch_a: assert property (
        ((cyc_cmp ^ cmp_base(ctrl_ff[2], base_ff[2], gran_ff[GRAN_BASE_LO + 2]))
         & ~cmp_mask(ctrl_ff[2], gran_ff[GRAN_MASK_LO + 2])) != '0
        |=> programmable_select_n[2])
        else $error("Select 2 asserted on an unmasked address mismatch.");

    buffer_dir_a: assert property (
        !peripheral_buffer_direction
        |-> $past(!peripheral_buffer_direction_in || (|rd_hit)))
        else $error("Buffer direction low without a cause.");

    gran_write_a: assert property (
        !$stable(gran_ff) |-> $past(wr_en && reg_idx == IDX_GRAN))
        else $error("Granularity register changed without a write.");

    base_write_a: assert property (
        wr_en && reg_idx == IDX_BASE0 |=> base_ff[0] == $past(pwdata[7:0]))
        else $error("Base register 0 did not take the written value.");

    rom_width_a: assert property (
        !rom_select_cycle |-> !rom_select_wide)
        else $error("Wide ROM flag without a ROM select cycle.");

    global_sel1_a: assert property (
        global_ff[GLB_DIS_LO + 1]
        |=> programmable_select_n[1])
        else $error("Select 1 asserted while globally disabled.");

    global_sel3_a: assert property (
        global_ff[GLB_DIS_LO + 3]
        |=> programmable_select_n[3])
        else $error("Select 3 asserted while globally disabled.");

    cmd_sel0_a: assert property (
        !ctrl_ff[0][CTRL_EARLY] && !cyc_cmd
        |=> programmable_select_n[0])
        else $error("Select 0 asserted before the command.");

    addr_sel0_a: assert property (
        ((cyc_cmp ^ cmp_base(ctrl_ff[0], base_ff[0], gran_ff[GRAN_BASE_LO]))
         & ~cmp_mask(ctrl_ff[0], gran_ff[GRAN_MASK_LO])) != '0 |=> programmable_select_n[0])
        else $error("Select 0 asserted on an unmasked address mismatch.");

    sel1_read_a: assert property (
        cyc_valid && !cyc_is_write && !ctrl_ff[1][CTRL_RD_EN]
        |=> programmable_select_n[1])
        else $error("Select 1 asserted on a read with read decode off.");

    sel1_write_a: assert property (
        cyc_valid && cyc_is_write && !ctrl_ff[1][CTRL_WR_EN]
        |=> programmable_select_n[1])
        else $error("Select 1 asserted on a write with write decode off.");

    sel1_type_a: assert property (
        cyc_is_mem != cyc_type_ff[TYPE_MEM_LO + 1]
        |=> programmable_select_n[1])
        else $error("Select 1 asserted on the wrong cycle type.");

    sel3_type_a: assert property (
        cyc_is_mem != cyc_type_ff[TYPE_MEM_LO + 3]
        |=> programmable_select_n[3])
        else $error("Select 3 asserted on the wrong cycle type.");

    no_valid_a: assert property (
        !cyc_valid
        |=> &programmable_select_n)
        else $error("A select asserted with no bus cycle.");

    io_top_a: assert property (
        cyc_valid && !cyc_is_mem && (cyc_addr[IO_CMP_LO + CMP_W - 1] != ctrl_ff[0][CTRL_TOP_BIT])
        |=> programmable_select_n[0])
        else $error("Select 0 asserted with the top I/O bit mismatched.");

    mem_top_a: assert property (
        cyc_valid && cyc_is_mem && (cyc_addr[MEM_CMP_LO + CMP_W - 1] != ctrl_ff[1][CTRL_TOP_BIT])
        |=> programmable_select_n[1])
        else $error("Select 1 asserted with the top memory bit mismatched.");

    io_base_a: assert property (
        cyc_valid && !cyc_is_mem && (cyc_addr[IO_CMP_LO + CTRL_MASK_W + 1 +: CTRL_MASK_W]
            != base_ff[0][CTRL_TOP_BIT -: CTRL_MASK_W]) |=> programmable_select_n[0])
        else $error("Select 0 asserted with unmaskable I/O base bits mismatched.");

    mem_base_a: assert property (
        cyc_valid && cyc_is_mem && (cyc_addr[MEM_CMP_LO + CTRL_MASK_W + 1 +: CTRL_MASK_W]
            != base_ff[1][CTRL_TOP_BIT -: CTRL_MASK_W]) |=> programmable_select_n[1])
        else $error("Select 1 asserted with unmaskable memory base bits mismatched.");

    gran_low_a: assert property (
        cyc_valid && !cyc_is_mem && !gran_ff[GRAN_MASK_LO] && (cyc_addr[IO_CMP_LO] != gran_ff[GRAN_BASE_LO])
        |=> programmable_select_n[0])
        else $error("Select 0 asserted with the lowest bit mismatched.");

    rom_io_a: assert property (
        !cyc_is_mem
        |=> !rom_select_cycle)
        else $error("ROM select cycle flagged on an I/O cycle.");

    dir_pass_a: assert property (
        peripheral_buffer_direction_in && !(cyc_valid && !cyc_is_write)
        |=> peripheral_buffer_direction)
        else $error("Buffer direction pulled low outside a read.");

    dir_in_a: assert property (
        !peripheral_buffer_direction_in
        |=> !peripheral_buffer_direction)
        else $error("Buffer direction did not follow its input low.");

    global_write_a: assert property (
        !$stable(global_ff)
        |-> $past(wr_en && reg_idx == IDX_GLOBAL))
        else $error("Global control register changed without a write.");

    ctrl_keep_a: assert property (
        wr_en && reg_idx == IDX_GLOBAL
        |=> $stable(ctrl_ff[1]))
        else $error("Control register 1 changed on a global write.");

    rom_sel_a: assert property (
        rom_select_cycle
        |-> !(&programmable_select_n))
        else $error("ROM select cycle flagged with no select asserted.");

endmodule

// >>> verif/pcs_isa_peer.sv
// Far-side peer model: the ISA peripherals and ROMs behind the selects.
// Assumes active-low selects that are sampled on pclk.
module pcs_isa_peer
    import pcs_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [NUM_SEL-1:0] programmable_select_n,
    output logic      [NUM_SEL-1:0] seen_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each device remembers that it was selected at least once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= '0;
        end else begin
            seen_ff <= seen_ff | ~programmable_select_n;
        end
    end
endmodule

// >>> verif/programmable_chip_select_decoder_test.sv
// Testbench for the select decoder: APB register access and bus cycles.
// Assumes the design answers APB with zero waits and decodes one cycle late.
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module programmable_chip_select_decoder_test
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, dir, rcyc, rwide;
    logic        cv = 0, cm = 0, cw = 0, cc = 0, dir_in = 1;
    logic [23:0] ca = '0;
    logic [3:0]  sel_n, seen;
    int          fails = 0, comparisons = 0;
    logic [9:0]  tab [11] = '{IDX_BASE0, IDX_CTRL0, IDX_BASE1, IDX_CTRL1, IDX_CYC_TYPE,
        IDX_BASE2, IDX_CTRL2, IDX_BASE3, IDX_CTRL3, IDX_GRAN, IDX_GLOBAL};
    int          bpos [4] = '{0, 2, 5, 7};

    always #10 pclk = ~pclk;

    pcs_decoder u_pcs_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc_valid(cv),
        .cyc_is_mem(cm), .cyc_is_write(cw), .cyc_cmd(cc), .cyc_addr(ca),
        .peripheral_buffer_direction_in(dir_in), .programmable_select_n(sel_n),
        .peripheral_buffer_direction(dir), .rom_select_cycle(rcyc),
        .rom_select_wide(rwide));

    pcs_isa_peer u_pcs_isa_peer (.pclk(pclk), .presetn(presetn),
        .programmable_select_n(sel_n), .seen_ff(seen));

    task final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
            final_report();
        end
    endtask

    task cyc(input logic m, input logic w, input logic c, input logic [23:0] a);
        @(posedge pclk);
        cv <= 1'b1;
        cm <= m;
        cw <= w;
        cc <= c;
        ca <= a;
        @(posedge pclk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK("sel idle", 4'hf, sel_n)
        for (int i = 0; i < 11; i++) begin
            apb(0, tab[i], 8'h00);
            `CHK("reset", (i == 9) ? 32'h0f : 32'h0, rd)
            apb(1, tab[i], 8'h5a ^ 8'(i));
            apb(0, tab[i], 8'h00);
            `CHK("rw", {24'h0, 8'h5a ^ 8'(i)}, rd)
            apb(1, tab[i], (i == 9) ? 8'h0f : 8'h00);
        end
        apb(1, 10'h000, 8'hff);
        `CHK("unmapped err", 1'b1, err)
        apb(0, 10'h000, 8'h00);
        `CHK("unmapped rd", 32'h0, rd)
        for (int n = 0; n < 4; n++) begin
            apb(1, tab[bpos[n] + 1], 8'he0);
            apb(1, tab[bpos[n]], 8'h40 + 8'(n));
            cyc(0, 0, 1, {14'h0, 1'b1, 8'h40 + 8'(n), 1'b1});
            `CHK("sel each", ~(4'h1 << n), sel_n)
            apb(1, tab[bpos[n] + 1], 8'h00);
        end
        `CHK("peer seen", 4'hf, seen)
        apb(1, IDX_CTRL0, 8'he0);
        apb(1, IDX_BASE0, 8'h12);
        cyc(0, 0, 1, 24'h000225);
        `CHK("io hit", 4'he, sel_n)
        cyc(0, 0, 1, 24'h000025);
        `CHK("io a9", 4'hf, sel_n)
        cyc(1, 0, 1, 24'h000225);
        `CHK("mem on io", 4'hf, sel_n)
        cyc(0, 0, 1, 24'h000226);
        `CHK("io a1", 4'hf, sel_n)
        apb(1, IDX_CTRL0, 8'he1);
        cyc(0, 0, 1, 24'h000226);
        `CHK("mask a1", 4'he, sel_n)
        apb(1, IDX_CTRL0, 8'he0);
        apb(1, IDX_GRAN, 8'h10);
        cyc(0, 0, 1, 24'h000224);
        `CHK("gran a0 miss", 4'hf, sel_n)
        cyc(0, 0, 1, 24'h000225);
        `CHK("gran a0 hit", 4'he, sel_n)
        apb(1, IDX_GRAN, 8'h0f);
        apb(1, IDX_CTRL0, 8'hc0);
        cyc(0, 0, 1, 24'h000225);
        `CHK("rd off", 4'hf, sel_n)
        cyc(0, 1, 1, 24'h000225);
        `CHK("wr on", 4'he, sel_n)
        apb(1, IDX_CTRL0, 8'ha0);
        cyc(0, 1, 1, 24'h000225);
        `CHK("wr off", 4'hf, sel_n)
        apb(1, IDX_CTRL0, 8'he0);
        cyc(0, 0, 0, 24'h000225);
        `CHK("no cmd", 4'hf, sel_n)
        apb(1, IDX_CTRL0, 8'hf0);
        cyc(0, 0, 0, 24'h000225);
        `CHK("early", 4'he, sel_n)
        apb(1, IDX_CTRL0, 8'h00);
        apb(1, IDX_CYC_TYPE, 8'h22);
        apb(1, IDX_CTRL1, 8'he0);
        apb(1, IDX_BASE1, 8'h15);
        cyc(1, 0, 1, 24'h8ac000);
        `CHK("mem hit", 4'hd, sel_n)
        `CHK("rom cyc", 1'b1, rcyc)
        `CHK("rom wide", 1'b1, rwide)
        cyc(1, 0, 1, 24'h0ac000);
        `CHK("mem a23", 4'hf, sel_n)
        apb(1, IDX_CYC_TYPE, 8'h02);
        cyc(1, 0, 1, 24'h8ac000);
        `CHK("rom narrow", 1'b0, rwide)
        apb(1, IDX_GLOBAL, 8'h20);
        cyc(1, 0, 1, 24'h8ac000);
        `CHK("glb off", 4'hf, sel_n)
        apb(0, IDX_CTRL1, 8'h00);
        `CHK("ctrl kept", 32'he0, rd)
        apb(1, IDX_GLOBAL, 8'h02);
        cyc(1, 0, 1, 24'h8ac000);
        `CHK("dir rd", 1'b0, dir)
        cyc(1, 1, 1, 24'h8ac000);
        `CHK("dir wr", 1'b1, dir)
        apb(1, IDX_GLOBAL, 8'h00);
        cyc(1, 0, 1, 24'h8ac000);
        `CHK("dir off", 1'b1, dir)
        cv <= 1'b0;
        final_report();
    end
endmodule
